//--- src/bms_cmd_pkg.sv
// Constants and carrier types for the battery manager serial front end.
// Shared by the front end module and the bench that drives it.
package bms_cmd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Command word layout: payload bit index counted after the start bit
   localparam int          WORD_BITS  = 22;
   localparam int          CMD_BITS   = 21;
   localparam logic [4:0]  CMD_LAST   = 5'h14;
   localparam int          F_MODE_LO  = 0;
   localparam int          F_MODE_HI  = 1;
   localparam logic [4:0]  MODE_LAST  = 5'h01;
   localparam int          F_DIFF     = 2;
   localparam int          F_ORDER    = 3;
   localparam int          F_SRC      = 4;
   localparam int          F_RATIO    = 7;
   localparam int          F_PDOWN    = 11;
   localparam int          F_DUTY     = 12;
   localparam int          F_FCLR     = 15;
   localparam int          F_TOUT     = 16;
   localparam int          F_REF      = 19;
   localparam logic [20:0] CMD_RESET  = 21'h000000;

   ////////////////////////////////////////////////////////////////////////
   // Answer framing, in serial clock cycles
   localparam int          RES_BITS   = 10;
   localparam int          STAT_BITS  = 8;
   localparam logic [4:0]  CONV_LAST  = 5'h02;
   localparam logic [4:0]  SEND_MSB   = 5'h11;
   localparam logic [4:0]  SEND_BOTH  = 5'h1a;
   localparam logic [4:0]  LSB_START  = 5'h0a;
   localparam logic [4:0]  STAT_BOTH  = 5'h13;

   ////////////////////////////////////////////////////////////////////////
   // Charge PWM timing
   localparam int          CLK_HZ     = 250000000;
   localparam int          PWM_HZ     = 111000;
   localparam int          PWM_CYC    = CLK_HZ / PWM_HZ;
   localparam logic [11:0] PWM_LAST   = 12'(PWM_CYC - 1);

   typedef enum logic [1:0] {
      MODE_IDLE  = 2'h0,
      MODE_DISCH = 2'h1,
      MODE_CHRG  = 2'h2,
      MODE_GAUGE = 2'h3
   } mode_e;

   typedef enum logic [4:0] {
      ST_HUNT = 5'h01,
      ST_CMD  = 5'h02,
      ST_CONV = 5'h04,
      ST_SEND = 5'h08,
      ST_DONE = 5'h10
   } link_st_e;

   // Decoded controls toward the analog section
   typedef struct packed {
      mode_e      mode;
      logic       analog_on;
      logic       regulator_on;
      logic       divider_on;
      logic       drain_drive;
      logic       pfet_drive;
      logic       gauge_on;
      logic       diff_select;
      logic [2:0] adc_source;
      logic [3:0] cell_ratio;
      logic [2:0] loop_duty;
      logic       fault_clear;
      logic [2:0] timeout_sel;
      logic [1:0] loop_ref;
   } ctrl_s;

endpackage : bms_cmd_pkg

//--- src/bms_serial_cmd.sv
// Serial command front end and mode control of the battery manager.
// Assumes the host owns the serial clock and frame select, and that
// the ADC core runs on the same serial clock and presents its result
// by the end of the conversion cycles.
//
// Behaviour
// - Output bit changes on falling clock edge
// - Input bit captured on rising clock edge
// - Data in and out may share one wire
// - Command, conversion, then result and status out
// - Command word is 22 bits with start
// - Power-up clears the whole command word
// - Leading zeros ignored; first one starts frame
// - Payload fields arrive in fixed order
// - Mode bits decode idle, discharge, charge, gauge
// - Mode applied as soon as captured
// - Diff select picks ground or shunt reference
// - Bit order: MSB only, or MSB then LSB
// - Source codes route the five ADC inputs
// - Shutdown kills analog, regulator and divider
// - Idle keeps power, all functions off
// - Discharge mode drives drain output high
// - Divider ratio programmable, off in shutdown/gauge
// - Charge mode switches pfet at 111kHz
// - Gauge mode offers amplified shunt as source
// - Power down bit shuts all but inputs
// - Fault clear drops when frame select rises
// - Status word is eight bits
`timescale 1ns/1ns

module bms_serial_cmd
(
   input  wire logic               i_clk,
   input  wire logic               i_srst,
   input  wire logic               i_sclk,
   input  wire logic               i_cs_n,
   input  wire logic               i_sdi,
   input  wire logic [9:0]         i_adc_result,
   input  wire logic [7:0]         i_fault_status,
   input  wire logic               i_shunt_high,
   output logic                    o_sdo,
   output logic                    o_sdo_oe,
   output logic                    o_adc_convert,
   output bms_cmd_pkg::ctrl_s      o_ctrl
);
   import bms_cmd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State carriers, one per clock domain and edge

   typedef struct packed {
      link_st_e    st;
      logic [4:0]  cnt;
      logic [20:0] cmd;
      logic [9:0]  res;
      logic [7:0]  stat;
      logic [7:0]  stat_s1;
      logic [7:0]  stat_s2;
      logic        mode_vld;
      logic        word_vld;
      logic        conv;
   } link_s;

   typedef struct packed {
      logic dout;
      logic oe;
   } drv_s;

   typedef struct packed {
      logic        cs_s1;
      logic        cs_s2;
      logic        mv_s1;
      logic        mv_s2;
      logic        mv_s3;
      logic        wv_s1;
      logic        wv_s2;
      logic        wv_s3;
      logic        sh_s1;
      logic        sh_s2;
      logic [20:0] cmd;
      logic [11:0] pwm_cnt;
      logic        pwm_on;
      ctrl_s       ctrl;
   } sys_s;

   link_s lnk_r;
   link_s lnk_nxt;
   drv_s  drv_r;
   drv_s  drv_nxt;
   sys_s  sys_r;
   sys_s  sys_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Bit k of the answer stream: result MSB first, optional LSB-first
   // repeat that shares the LSB, then status MSB first.
   function automatic logic out_bit(input logic [4:0] k,
                                    input logic       msb_only,
                                    input logic [9:0] res,
                                    input logic [7:0] stat);
      logic [4:0] j;
      logic       b;
      j = 5'h00;
      b = 1'b0;
      if (k < LSB_START)
      begin
         j = 5'(RES_BITS - 1) - k;
         b = res[j[3:0]];
      end
      else if (!msb_only && k < STAT_BOTH)
      begin
         j = k - 5'(RES_BITS - 1);
         b = res[j[3:0]];
      end
      else
      begin
         j = msb_only ? (SEND_MSB - k) : (SEND_BOTH - k);
         b = stat[j[2:0]];
      end
      return b;
   endfunction : out_bit

   function automatic mode_e mode_of(input logic [20:0] c);
      return mode_e'({c[F_MODE_HI], c[F_MODE_LO]});
   endfunction : mode_of

   ////////////////////////////////////////////////////////////////////////
   // Link side, rising edge of the serial clock.
   // Frame select high clears it, so nothing relies on clock edges
   // outside a frame.

   always_comb
   begin
      lnk_nxt         = lnk_r;
      lnk_nxt.stat_s1 = i_fault_status;
      lnk_nxt.stat_s2 = lnk_r.stat_s1;
      case (lnk_r.st)
         ST_HUNT:
         begin
            if (i_sdi)
            begin
               lnk_nxt.st  = ST_CMD;
               lnk_nxt.cnt = 5'h00;
            end
         end
         ST_CMD:
         begin
            lnk_nxt.cmd[lnk_r.cnt] = i_sdi;
            lnk_nxt.cnt            = lnk_r.cnt + 5'h01;
            if (lnk_r.cnt == MODE_LAST)
            begin
               lnk_nxt.mode_vld = 1'b1;
            end
            if (lnk_r.cnt == CMD_LAST)
            begin
               lnk_nxt.st       = ST_CONV;
               lnk_nxt.cnt      = 5'h00;
               lnk_nxt.word_vld = 1'b1;
            end
         end
         ST_CONV:
         begin
            lnk_nxt.cnt = lnk_r.cnt + 5'h01;
            if (lnk_r.cnt == CONV_LAST)
            begin
               lnk_nxt.st   = ST_SEND;
               lnk_nxt.cnt  = 5'h00;
               lnk_nxt.res  = i_adc_result;
               lnk_nxt.stat = lnk_r.stat_s2;
            end
         end
         ST_SEND:
         begin
            lnk_nxt.cnt = lnk_r.cnt + 5'h01;
            if (lnk_r.cnt == (lnk_r.cmd[F_ORDER] ?
                              SEND_MSB : SEND_BOTH))
            begin
               lnk_nxt.st = ST_DONE;
            end
         end
         ST_DONE:
         begin
            lnk_nxt.cnt = lnk_r.cnt;
         end
         default:
         begin
            lnk_nxt.st = ST_HUNT;
         end
      endcase
      lnk_nxt.conv = (lnk_nxt.st == ST_CONV);
   end

   always_ff @(posedge i_sclk or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         lnk_r     <= '0;
         lnk_r.st  <= ST_HUNT;
      end
      else
      begin
         lnk_r <= lnk_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link side, falling edge: data out and its enable.
   // Enable stays low while command bits arrive, so a shared data wire
   // never sees two drivers.

   always_comb
   begin
      drv_nxt.oe   = (lnk_r.st == ST_CONV) ||
                     (lnk_r.st == ST_SEND) ||
                     (lnk_r.st == ST_DONE);
      drv_nxt.dout = 1'b0;
      if (lnk_r.st == ST_SEND)
      begin
         drv_nxt.dout = out_bit(lnk_r.cnt, lnk_r.cmd[F_ORDER],
                                lnk_r.res, lnk_r.stat);
      end
   end

   always_ff @(negedge i_sclk or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         drv_r <= '0;
      end
      else
      begin
         drv_r <= drv_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System side: crossings, command store, mode decode, charge PWM

   always_comb
   begin
      sys_nxt       = sys_r;
      sys_nxt.cs_s1 = i_cs_n;
      sys_nxt.cs_s2 = sys_r.cs_s1;
      sys_nxt.mv_s1 = lnk_r.mode_vld;
      sys_nxt.mv_s2 = sys_r.mv_s1;
      sys_nxt.mv_s3 = sys_r.mv_s2;
      sys_nxt.wv_s1 = lnk_r.word_vld;
      sys_nxt.wv_s2 = sys_r.wv_s1;
      sys_nxt.wv_s3 = sys_r.wv_s2;
      sys_nxt.sh_s1 = i_shunt_high;
      sys_nxt.sh_s2 = sys_r.sh_s1;

      // Clear first so that a word landing in the same cycle wins
      if (sys_r.cs_s2)
      begin
         sys_nxt.cmd[F_FCLR] = 1'b0;
      end
      // Link words hold still until frame select rises, which is long
      // after the valid level has crossed.
      if (sys_r.mv_s2 && !sys_r.mv_s3)
      begin
         sys_nxt.cmd[F_MODE_HI:F_MODE_LO] =
            lnk_r.cmd[F_MODE_HI:F_MODE_LO];
      end
      if (sys_r.wv_s2 && !sys_r.wv_s3)
      begin
         sys_nxt.cmd = lnk_r.cmd;
      end

      // Free-running period; the shunt comparator ends each on-time
      if (sys_r.pwm_cnt == PWM_LAST)
      begin
         sys_nxt.pwm_cnt = 12'h000;
      end
      else
      begin
         sys_nxt.pwm_cnt = sys_r.pwm_cnt + 12'h001;
      end
      if (sys_r.pwm_cnt == 12'h000)
      begin
         sys_nxt.pwm_on = 1'b1;
      end
      else if (sys_r.sh_s2)
      begin
         sys_nxt.pwm_on = 1'b0;
      end

      sys_nxt.ctrl.mode         = mode_of(sys_nxt.cmd);
      sys_nxt.ctrl.analog_on    = !sys_nxt.cmd[F_PDOWN];
      sys_nxt.ctrl.regulator_on = !sys_nxt.cmd[F_PDOWN];
      sys_nxt.ctrl.divider_on   = !sys_nxt.cmd[F_PDOWN] &&
         (sys_nxt.ctrl.mode != MODE_GAUGE);
      sys_nxt.ctrl.drain_drive  = !sys_nxt.cmd[F_PDOWN] &&
         (sys_nxt.ctrl.mode == MODE_DISCH);
      sys_nxt.ctrl.pfet_drive   = !sys_nxt.cmd[F_PDOWN] &&
         (sys_nxt.ctrl.mode == MODE_CHRG) &&
         sys_nxt.pwm_on;
      sys_nxt.ctrl.gauge_on     = !sys_nxt.cmd[F_PDOWN] &&
         (sys_nxt.ctrl.mode == MODE_GAUGE);
      sys_nxt.ctrl.diff_select  = sys_nxt.cmd[F_DIFF];
      sys_nxt.ctrl.adc_source   =
         sys_nxt.cmd[F_SRC+2:F_SRC];
      sys_nxt.ctrl.cell_ratio   =
         sys_nxt.cmd[F_RATIO+3:F_RATIO];
      sys_nxt.ctrl.loop_duty    = sys_nxt.cmd[F_DUTY+2:F_DUTY];
      sys_nxt.ctrl.fault_clear  = sys_nxt.cmd[F_FCLR];
      sys_nxt.ctrl.timeout_sel  = sys_nxt.cmd[F_TOUT+2:F_TOUT];
      sys_nxt.ctrl.loop_ref     = sys_nxt.cmd[F_REF+1:F_REF];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         sys_r     <= '0;
         sys_r.cmd <= CMD_RESET;
      end
      else
      begin
         sys_r <= sys_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_sdo         = drv_r.dout;
   assign o_sdo_oe      = drv_r.oe;
   assign o_adc_convert = lnk_r.conv;
   assign o_ctrl        = sys_r.ctrl;

endmodule : bms_serial_cmd

//--- verification/bms_serial_cmd_asserts.sv
// Port level checks for the battery manager serial front end.
// Assumes the host holds the serial clock still outside frames.
`timescale 1ns/1ns

module bms_serial_cmd_checker
(
   input  wire logic               i_clk,
   input  wire logic               i_srst,
   input  wire logic               i_sclk,
   input  wire logic               i_cs_n,
   input  wire logic               o_sdo,
   input  wire logic               o_sdo_oe,
   input  wire logic               o_adc_convert,
   input  wire bms_cmd_pkg::ctrl_s o_ctrl
);
   import bms_cmd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Serial link side: the frame select is this domain's reset
   oe_released_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_cs_n |-> !o_sdo_oe) else $error("data out driven while deselected");
   sdo_on_fall_a: assert property (@(posedge i_clk)
      disable iff (i_cs_n) $changed(o_sdo) |-> !i_sclk)
      else $error("data out moved while serial clock high");
   conv_length_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
      $rose(o_adc_convert) |-> o_adc_convert[*3] ##1 !o_adc_convert)
      else $error("conversion phase not three clocks");
   conv_quiet_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
      o_adc_convert |-> o_sdo_oe && !o_sdo)
      else $error("data out not low during conversion");

   ////////////////////////////////////////////////////////////////////////
   // System side controls
   reset_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
      $past(i_srst) |-> o_ctrl.mode == MODE_IDLE && !o_ctrl.fault_clear
      && o_ctrl.cell_ratio == 4'h0 && o_ctrl.loop_ref == 2'h0)
      else $error("controls not cleared by reset");
   drain_mode_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ctrl.drain_drive == (o_ctrl.mode == MODE_DISCH && o_ctrl.analog_on))
      else $error("drain drive does not follow discharge mode");
   idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ctrl.mode == MODE_IDLE |-> !o_ctrl.pfet_drive && !o_ctrl.gauge_on)
      else $error("function active in idle");
   shutdown_off_a: assert property (@(posedge i_clk) disable iff (i_srst)
      !o_ctrl.analog_on |-> !(o_ctrl.regulator_on | o_ctrl.divider_on
      | o_ctrl.pfet_drive | o_ctrl.gauge_on))
      else $error("analog section alive in shutdown");
   divider_off_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ctrl.mode == MODE_GAUGE |-> !o_ctrl.divider_on)
      else $error("divider connected in gauge mode");
   gauge_path_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ctrl.gauge_on == (o_ctrl.mode == MODE_GAUGE && o_ctrl.analog_on))
      else $error("gauge path does not follow mode");
   pfet_mode_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ctrl.pfet_drive |-> o_ctrl.mode == MODE_CHRG)
      else $error("pfet switching outside charge mode");
   fclr_drop_a: assert property (@(posedge i_clk) disable iff (i_srst)
      $rose(i_cs_n) |-> ##[1:6] !o_ctrl.fault_clear)
      else $error("fault clear kept after deselect");

   cover property (@(posedge i_sclk) $rose(o_adc_convert));
   cover property (@(posedge i_clk) o_ctrl.pfet_drive);
   cover property (@(posedge i_clk) o_ctrl.mode == MODE_GAUGE);
endmodule : bms_serial_cmd_checker

bind bms_serial_cmd bms_serial_cmd_checker chk_i (.i_clk(i_clk),
   .i_srst(i_srst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_sdo(o_sdo),
   .o_sdo_oe(o_sdo_oe), .o_adc_convert(o_adc_convert), .o_ctrl(o_ctrl));

//--- verification/host_link_model.sv
// Host side of the serial link: frames a command and collects the answer.
// Serial clock period 30 ns; it stands low between frames.
`timescale 1ns/1ns

module host_link_model
(
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_sdi
);
   logic        drv = 1'b1;
   logic        three = 1'b0;
   logic [29:0] ans;
   int          bitn = 0;
   int          viol = 0;

   initial o_sclk = 1'b0;
   // A clean rising edge on frame select clears the link logic before
   // the first frame; a plain start at high might not be seen as an edge.
   initial
   begin
      o_cs_n = 1'b0;
      #1 o_cs_n = 1'b1;
   end
   // Shared wire: the device wins while enabled, else the host level
   assign o_sdi = (three && i_sdo_oe) ? i_sdo : drv;

   task automatic xfer(input logic [20:0] cmd, input int lead,
                       input bit tw, output logic [29:0] got);
      int          n;
      logic [21:0] word;
      n = cmd[3] ? 43 : 52;
      word = {cmd, 1'b1};
      three = tw;
      o_cs_n = 1'b0;
      #1000;
      for (int k = 1 - lead; k <= n; k++)
      begin
         // Past the command the host line toggles so stale bits never match
         drv = (k < 1) ? 1'b0 : (k <= 22) ? word[k-1] : ~drv;
         #15 o_sclk = 1'b1;
         bitn = k;
         if (k <= 22 && i_sdo_oe !== 1'b0)
            viol++;
         if (k > 22)
            ans[k-23] = three ? o_sdi : i_sdo;
         #15 o_sclk = 1'b0;
      end
      #15 o_cs_n = 1'b1;
      #1000;
      got = ans;
   endtask : xfer
endmodule : host_link_model

//--- verification/battery_manager_serial_command_bench.sv
// Self-checking bench for the battery manager serial front end.
// The host model owns the serial pins; the bench drives the rest.
`timescale 1ns/1ns

module battery_manager_serial_command_bench;
   import bms_cmd_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_sclk, i_cs_n, i_sdi, o_sdo, o_sdo_oe, o_adc_convert, last;
   logic [9:0]  i_adc_result = 10'h000;
   logic [7:0]  i_fault_status = 8'h00;
   logic        i_shunt_high = 1'b0;
   ctrl_s       o_ctrl;
   logic [20:0] prev = 21'h000000;
   logic [29:0] got;
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;
   int          rises;

   always #2 i_clk = ~i_clk;

   bms_serial_cmd DUT (.i_clk(i_clk), .i_srst(i_srst), .i_sclk(i_sclk),
      .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_adc_result(i_adc_result),
      .i_fault_status(i_fault_status), .i_shunt_high(i_shunt_high),
      .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_adc_convert(o_adc_convert),
      .o_ctrl(o_ctrl));
   host_link_model host (.i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe),
      .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi));

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic summarize;
      $display("Checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_count++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One full transaction and every check that follows from its word
   task automatic frame(input logic [20:0] cmd, input int lead, input bit tw);
      logic [9:0] res;
      logic [7:0] st;
      int         base;
      res = {cmd[9:5], ~cmd[4:0]};
      st = cmd[7:0] ^ 8'h5a;
      base = cmd[F_ORDER] ? 13 : 22;
      @(posedge i_clk);
      i_adc_result <= res;
      i_fault_status <= st;
      fork
         host.xfer(cmd, lead, tw, got);
         begin
            wait (host.bitn == 6);
            chk("early mode", o_ctrl.mode, cmd[1:0]);
            chk("held diff", o_ctrl.diff_select, prev[F_DIFF]);
            wait (host.bitn == 30);
            chk("fault clear", o_ctrl.fault_clear, cmd[F_FCLR]);
         end
      join
      repeat (8) @(posedge i_clk);
      chk("conv bits", got[2:0], 3'h0);
      chk("result", got[12:3], {<<{res}});
      if (!cmd[F_ORDER])
         chk("lsb repeat", got[21:13], res[9:1]);
      chk("status", got[base +: 8], {<<{st}});
      chk("oe in command", host.viol, 0);
      chk("fields", {o_ctrl.adc_source, o_ctrl.cell_ratio, o_ctrl.loop_duty,
         o_ctrl.timeout_sel, o_ctrl.loop_ref}, {cmd[6:4], cmd[10:7],
         cmd[14:12], cmd[18:16], cmd[20:19]});
      chk("diff", o_ctrl.diff_select, cmd[F_DIFF]);
      chk("drain", o_ctrl.drain_drive, cmd[1:0] == 2'h1 && !cmd[11]);
      chk("power", {o_ctrl.analog_on, o_ctrl.regulator_on},
         {2{!cmd[F_PDOWN]}});
      chk("divider", o_ctrl.divider_on, !cmd[11] && cmd[1:0] != 2'h3);
      chk("gauge", o_ctrl.gauge_on, !cmd[11] && cmd[1:0] == 2'h3);
      chk("clear end", o_ctrl.fault_clear, 1'b0);
      prev = cmd;
   endtask : frame

   initial
   begin
      repeat (6) @(posedge i_clk);
      i_srst <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk("reset ctrl", o_ctrl, {2'h0, 3'h7, 20'h00000});
      frame({2'h3, 3'h7, 1'b1, 3'h4, 1'b0, 4'hf, 3'h4, 2'h3, 2'h1}, 3, 0);
      frame({2'h0, 3'h0, 1'b0, 3'h0, 1'b0, 4'h0, 3'h1, 2'h0, 2'h2}, 0, 1);
      // Window of exactly three periods holds exactly three pulse starts
      i_shunt_high <= 1'b1;
      repeat (20) @(posedge i_clk);
      rises = 0;
      last = o_ctrl.pfet_drive;
      repeat (3 * PWM_CYC)
      begin
         @(posedge i_clk);
         if (o_ctrl.pfet_drive === 1'b1 && last === 1'b0)
            rises++;
         last = o_ctrl.pfet_drive;
      end
      chk("pwm pulses", rises, 3);
      i_shunt_high <= 1'b0;
      frame({2'h1, 3'h2, 1'b0, 3'h3, 1'b0, 4'h5, 3'h0, 2'h3, 2'h3}, 1, 1);
      frame({2'h2, 3'h4, 1'b0, 3'h1, 1'b0, 4'h8, 3'h2, 2'h0, 2'h0}, 2, 0);
      frame({2'h0, 3'h1, 1'b0, 3'h2, 1'b1, 4'h3, 3'h3, 2'h3, 2'h1}, 0, 0);
      summarize();
   end
endmodule : battery_manager_serial_command_bench
